// *** design/ubr_baud_gen.sv ***
// Baud rate generator: integer prescaler followed by a power-of-two divider
`default_nettype none
module ubr_baud_gen (
	input  wire logic                   ref_clk,
	input  wire logic                   reset_n,
	input  wire logic                   enable,
	input  wire logic                   src_tick,
	input  wire ubr_pkg::ubr_baud_cfg_t cfg,
	output logic                        baud_tick,
	output logic                        baud_clk_out
);
	logic [6:0] pre_cnt;
	logic [6:0] pre_last;
	logic [6:0] pow_cnt;
	logic [6:0] pow_last;
	logic       pre_tick;

	// Prescaler divides by 65 minus the field, so 2 to 65
	assign pre_last = ubr_pkg::PRESCALE_BASE - {1'b0, cfg.prescale} - 7'h01;
	// Power-of-two divider: last count is 2**divide - 1
	assign pow_last = 7'h7f >> (3'h7 - cfg.divide);

	// Compare with >= so a lowered setting never strands the counter above its end
	assign pre_tick  = enable & src_tick & (pre_cnt >= pre_last);
	assign baud_tick = pre_tick & (pow_cnt >= pow_last);

	// Prescaler counter advances on each source tick
	always_ff @(posedge ref_clk) begin
		if (!reset_n || !enable) begin
			pre_cnt <= 7'h00;
		end else if (src_tick) begin
			pre_cnt <= pre_tick ? 7'h00 : pre_cnt + 7'h01;
		end
	end

	// Divider counter advances on each prescaler tick
	always_ff @(posedge ref_clk) begin
		if (!reset_n || !enable) begin
			pow_cnt <= 7'h00;
		end else if (pre_tick) begin
			pow_cnt <= baud_tick ? 7'h00 : pow_cnt + 7'h01;
		end
	end

	// Square wave for the clock pin: half the sampling rate, since it toggles per tick
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			baud_clk_out <= 1'b0;
		end else if (baud_tick) begin
			baud_clk_out <= ~baud_clk_out;
		end
	end
endmodule
`default_nettype wire

// *** design/ubr_pkg.sv ***
// Package: register map, field layout, carriers and timing constants of the UART baud and receive status block
`default_nettype none
package ubr_pkg;
	// Word addresses on the register bus (byte address is four times the index)
	localparam int         ADDR_W       = 3;
	localparam logic [2:0] REG_BAUD     = 3'h0;
	localparam logic [2:0] REG_RX       = 3'h1;
	localparam logic [2:0] REG_CTRL     = 3'h2;
	localparam logic [2:0] REG_IRQ_STAT = 3'h3;
	localparam logic [2:0] REG_IRQ_MASK = 3'h4;

	// Baud rate control layout
	localparam int          BAUD_DIR_BIT = 13;
	localparam int          BAUD_SOURCE_SEL_BIT = 11;
	localparam int          BAUD_DIV_LSB = 8;
	localparam int          BAUD_PRE_LSB = 0;
	localparam logic [15:0] BAUD_WR_MASK = 16'h2f3f;
	localparam logic [15:0] BAUD_RESET   = 16'h0000;

	// UART status control layout
	localparam int          CTRL_UEN_BIT      = 15;
	localparam int          CTRL_RECEIVER_ENABLE_BIT_BIT     = 14;
	localparam int          CTRL_STALE_EN_BIT = 7;
	localparam int          CTRL_FULL_EN_BIT  = 5;
	localparam int          CTRL_HALF_EN_BIT  = 4;
	localparam int          CTRL_RDY_EN_BIT   = 3;
	localparam logic [15:0] CTRL_WR_MASK      = 16'hc0b8;
	localparam logic [15:0] CTRL_RESET        = 16'h0000;

	// Receive status and data layout
	localparam int RX_FULL_BIT  = 15;
	localparam int RX_HALF_BIT  = 14;
	localparam int RX_READY_BIT = 13;
	localparam int RX_OLD_BIT   = 12;
	localparam int RX_OVR_BIT   = 11;

	// Interrupt status and mask layout
	localparam int         IRQ_W        = 5;
	localparam int         IRQ_FULL     = 0;
	localparam int         IRQ_HALF     = 1;
	localparam int         IRQ_READY    = 2;
	localparam int         IRQ_OLD      = 3;
	localparam int         IRQ_OVR      = 4;
	localparam logic [4:0] IRQ_RESET    = 5'h00;

	// Rate generator and receiver timing
	localparam logic [6:0] PRESCALE_BASE   = 7'h41;
	localparam logic [4:0] OLD_DATA_BITS   = 5'h1e;
	localparam logic [3:0] SAMPLE_MID      = 4'h7;
	localparam logic [3:0] SAMPLE_LAST     = 4'hf;
	localparam int         HALF_FREE_SLOTS = 4;

	typedef struct packed {
		logic [2:0] divide;
		logic [5:0] prescale;
	} ubr_baud_cfg_t;

	typedef struct packed {
		logic       overrun;
		logic [7:0] data;
	} ubr_rx_entry_t;

	typedef enum {
		RX_IDLE,
		RX_START,
		RX_DATA,
		RX_STOP
	} ubr_rx_state_t;
endpackage
`default_nettype wire

// *** design/ubr_uart_baud_rx.sv ***
// UART channel: baud generator control, receiver, receive FIFO, status register and interrupts
`default_nettype none
// Behaviour
// - Clock pin is input when direction bit 13 is 0, driven output when 1.
// - Source bit 11 picks system clock (0) or clock pin (1, direction must be 0).
// - Divide field bits 10..8 divides by two to the field value, 1 to 128.
// - Prescaler field bits 5..0 divides by 65 minus the field value.
// - A receiver register read brings the FIFO status bits to a valid state.
// - Per-character status is valid only in one full 16-bit read with data.
// - Bit 15 is 1 while the receive FIFO is full; maskable interrupt source.
// - Bit 14 is 1 with four or fewer free slots; maskable interrupt source.
// - Bit 13 is 1 while data is held; data valid only then; interrupt source.
// - Bit 12 set when data waited over 30 bit times, else 0; interrupt source.
// - Bit 11 marks a character that overwrote FIFO contents; updated per character.
// - Clearing receiver enable disables receiver and flushes the FIFO; resets to 0.
// - Control bit 7 gates the stale-data interrupt.
module ubr_uart_baud_rx #(
	parameter int FIFO_DEPTH = 8
) (
	input  wire logic                       ref_clk,
	input  wire logic                       reset_n,
	input  wire logic [ubr_pkg::ADDR_W-1:0] avs_address,
	input  wire logic                       avs_read,
	input  wire logic                       avs_write,
	input  wire logic [31:0]                avs_writedata,
	input  wire logic [3:0]                 avs_byteenable,
	output logic      [31:0]                avs_readdata,
	output logic                            avs_waitrequest,
	input  wire logic                       rx_line,
	input  wire logic                       uart_ext_clock_pin_in,
	output logic                            uart_ext_clock_pin_out,
	output logic                            uart_ext_clock_pin_oe,
	output logic                            irq
);
	localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	localparam int CW = $clog2(FIFO_DEPTH + 1);
	localparam logic [CW-1:0] DEPTH_C = CW'(FIFO_DEPTH);
	localparam logic [CW-1:0] HALF_C  = CW'(FIFO_DEPTH - ubr_pkg::HALF_FREE_SLOTS);

	// The half flag needs more than four slots and the status layout caps the depth
	if (FIFO_DEPTH < 5 || FIFO_DEPTH > 64) begin : g_bad_depth
		$error("FIFO_DEPTH must lie between 5 and 64");
	end

	// Pointer step with wrap for any depth
	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == PW'(FIFO_DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	function automatic logic [PW-1:0] ptr_dec(input logic [PW-1:0] p);
		ptr_dec = (p == '0) ? PW'(FIFO_DEPTH - 1) : p - PW'(1);
	endfunction

	// Byte-lane merge of a 16-bit register, keeping only writable bits
	function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [15:0] wd,
			input logic [1:0] be, input logic [15:0] mask);
		logic [15:0] lane;
		lane     = {{8{be[1]}}, {8{be[0]}}} & mask;
		be_merge = (old & ~lane) | (wd & lane);
	endfunction

	logic [15:0]                 baud_cfg;
	logic [15:0]                 ctrl;
	logic [ubr_pkg::IRQ_W-1:0]   irq_status;
	logic [ubr_pkg::IRQ_W-1:0]   irq_mask;
	logic [ubr_pkg::IRQ_W-1:0]   irq_set;
	logic [ubr_pkg::IRQ_W-1:0]   irq_clr;
	logic [ubr_pkg::IRQ_W-1:0]   irq_gate;
	logic                        served;
	logic                        req;
	logic                        done;
	logic                        wr_done;
	logic                        rd_had_data;
	logic                        status_valid;
	logic                        char_read;
	logic                        fifo_pop;
	logic [15:0]                 rx_word;
	logic [15:0]                 next_readdata;
	ubr_pkg::ubr_rx_entry_t      fifo_mem [FIFO_DEPTH];
	ubr_pkg::ubr_rx_entry_t      head;
	logic [PW-1:0]               wr_ptr;
	logic [PW-1:0]               rd_ptr;
	logic [CW-1:0]               count;
	logic                        fifo_full;
	logic                        fifo_half;
	logic                        fifo_ready;
	logic                        fifo_old;
	logic                        overwrite;
	logic                        flush;
	logic [4:0]                  age;
	logic [3:0]                  bit_div;
	logic                        bit_tick;
	logic                        pin_prev;
	logic                        src_sel_pin;
	logic                        src_tick;
	logic                        baud_tick;
	logic                        baud_clk;
	logic                        rx_on;
	ubr_pkg::ubr_rx_state_t      rx_state;
	logic [3:0]                  samp_cnt;
	logic [2:0]                  bit_idx;
	logic [7:0]                  shreg;
	logic                        rx_push;
	logic [7:0]                  rx_char;
	ubr_pkg::ubr_baud_cfg_t      gen_cfg;

	// Bus handshake: one wait state, so read data can come from a flop
	assign req             = avs_read | avs_write;
	assign avs_waitrequest = req & ~served;
	assign done            = req & served;
	assign wr_done         = done & avs_write;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			served <= 1'b0;
		end else begin
			served <= req & ~served;
		end
	end

	// Software-visible control registers
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			baud_cfg <= ubr_pkg::BAUD_RESET;
			ctrl     <= ubr_pkg::CTRL_RESET;
			irq_mask <= ubr_pkg::IRQ_RESET;
		end else if (wr_done) begin
			unique case (avs_address)
				ubr_pkg::REG_BAUD: begin
					// Reserved bits are never stored, whatever software writes
					baud_cfg <= be_merge(baud_cfg, avs_writedata[15:0], avs_byteenable[1:0],
						ubr_pkg::BAUD_WR_MASK);
				end
				ubr_pkg::REG_CTRL: begin
					ctrl <= be_merge(ctrl, avs_writedata[15:0], avs_byteenable[1:0], ubr_pkg::CTRL_WR_MASK);
				end
				ubr_pkg::REG_IRQ_MASK: begin
					if (avs_byteenable[0]) begin
						irq_mask <= avs_writedata[ubr_pkg::IRQ_W-1:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Receiver status word; overrun only shows on a full 16-bit access
	always_comb begin
		rx_word                       = 16'h0000;
		rx_word[ubr_pkg::RX_FULL_BIT]  = fifo_full;
		rx_word[ubr_pkg::RX_HALF_BIT]  = fifo_half;
		rx_word[ubr_pkg::RX_READY_BIT] = fifo_ready;
		rx_word[ubr_pkg::RX_OLD_BIT]   = fifo_old;
		rx_word[ubr_pkg::RX_OVR_BIT]   = fifo_ready & head.overrun & (avs_byteenable[1:0] == 2'h3);
		rx_word[7:0]                  = fifo_ready ? head.data : 8'h00;
	end

	// Read mux; unmapped words read as zero
	always_comb begin
		next_readdata = 16'h0000;
		unique case (avs_address)
			ubr_pkg::REG_BAUD:     next_readdata = baud_cfg;
			ubr_pkg::REG_RX:       next_readdata = rx_word;
			ubr_pkg::REG_CTRL:     next_readdata = ctrl;
			ubr_pkg::REG_IRQ_STAT: next_readdata = {11'h000, irq_status};
			ubr_pkg::REG_IRQ_MASK: next_readdata = {11'h000, irq_mask};
			default:               next_readdata = 16'h0000;
		endcase
	end

	// Read data is captured in the wait cycle and stands at the completing edge
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			avs_readdata <= 32'h0000_0000;
			rd_had_data  <= 1'b0;
		end else if (req & ~served) begin
			avs_readdata <= {16'h0000, next_readdata};
			rd_had_data  <= fifo_ready;
		end
	end

	// Pop only what software actually saw, so a char landing in the wait cycle is not lost
	assign char_read = done & avs_read & (avs_address == ubr_pkg::REG_RX) & avs_byteenable[0];
	assign fifo_pop  = char_read & rd_had_data;

	// Full, half, ready and stale events stay quiet until the first receiver read settles the FIFO flags
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			status_valid <= 1'b0;
		end else if (done & avs_read & (avs_address == ubr_pkg::REG_RX)) begin
			status_valid <= 1'b1;
		end
	end

	// Clock pin: output enable follows the direction bit
	assign uart_ext_clock_pin_oe  = baud_cfg[ubr_pkg::BAUD_DIR_BIT];
	assign uart_ext_clock_pin_out = baud_clk & baud_cfg[ubr_pkg::BAUD_DIR_BIT];

	// Pin edge detector; the pin is taken as synchronous to ref_clk
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pin_prev <= 1'b0;
		end else begin
			pin_prev <= uart_ext_clock_pin_in;
		end
	end

	// Pin source only counts while the pin is an input; driving it would feed our own output back
	assign src_sel_pin = baud_cfg[ubr_pkg::BAUD_SOURCE_SEL_BIT];
	assign src_tick    = src_sel_pin ? (uart_ext_clock_pin_in & ~pin_prev & ~baud_cfg[ubr_pkg::BAUD_DIR_BIT])
		: 1'b1;
	assign gen_cfg     = '{divide: baud_cfg[ubr_pkg::BAUD_DIV_LSB +: 3], prescale: baud_cfg[ubr_pkg::BAUD_PRE_LSB +: 6]};

	ubr_baud_gen u_baud_gen (
		.ref_clk      (ref_clk),
		.reset_n      (reset_n),
		.enable       (ctrl[ubr_pkg::CTRL_UEN_BIT]),
		.src_tick     (src_tick),
		.cfg          (gen_cfg),
		.baud_tick    (baud_tick),
		.baud_clk_out (baud_clk)
	);

	assign rx_on = ctrl[ubr_pkg::CTRL_UEN_BIT] & ctrl[ubr_pkg::CTRL_RECEIVER_ENABLE_BIT_BIT];
	assign flush = ~ctrl[ubr_pkg::CTRL_RECEIVER_ENABLE_BIT_BIT];

	// Receiver: 16x oversampling, start validated at mid-bit, LSB first
	always_ff @(posedge ref_clk) begin
		if (!reset_n || !rx_on) begin
			rx_state <= ubr_pkg::RX_IDLE;
			samp_cnt <= 4'h0;
			bit_idx  <= 3'h0;
			shreg    <= 8'h00;
			rx_push  <= 1'b0;
			rx_char  <= 8'h00;
		end else begin
			rx_push <= 1'b0;
			if (baud_tick) begin
				samp_cnt <= samp_cnt + 4'h1;
				unique case (rx_state)
					ubr_pkg::RX_IDLE: begin
						samp_cnt <= 4'h0;
						if (!rx_line) begin
							rx_state <= ubr_pkg::RX_START;
						end
					end
					ubr_pkg::RX_START: begin
						if (samp_cnt == ubr_pkg::SAMPLE_MID) begin
							// A short low glitch is not a start bit
							rx_state <= rx_line ? ubr_pkg::RX_IDLE : ubr_pkg::RX_DATA;
							samp_cnt <= 4'h0;
							bit_idx  <= 3'h0;
						end
					end
					ubr_pkg::RX_DATA: begin
						if (samp_cnt == ubr_pkg::SAMPLE_LAST) begin
							shreg   <= {rx_line, shreg[7:1]};
							bit_idx <= bit_idx + 3'h1;
							if (bit_idx == 3'h7) begin
								rx_state <= ubr_pkg::RX_STOP;
							end
						end
					end
					ubr_pkg::RX_STOP: begin
						if (samp_cnt == ubr_pkg::SAMPLE_LAST) begin
							// Characters without a stop bit are dropped
							rx_push  <= rx_line;
							rx_char  <= shreg;
							rx_state <= ubr_pkg::RX_IDLE;
						end
					end
				endcase
			end
		end
	end

	// FIFO flags
	assign fifo_full  = (count == DEPTH_C);
	assign fifo_half  = (count >= HALF_C);
	assign fifo_ready = (count != '0);
	assign head       = fifo_mem[rd_ptr];
	assign overwrite  = rx_push & fifo_full & ~fifo_pop;

	// FIFO storage: a char arriving when full with no pop in that cycle replaces the newest entry, marked as overrun
	always_ff @(posedge ref_clk) begin
		if (rx_push & ~fifo_full) begin
			fifo_mem[wr_ptr] <= '{overrun: 1'b0, data: rx_char};
		end else if (rx_push & fifo_pop) begin
			fifo_mem[wr_ptr] <= '{overrun: 1'b0, data: rx_char};
		end else if (overwrite) begin
			fifo_mem[ptr_dec(wr_ptr)] <= '{overrun: 1'b1, data: rx_char};
		end
	end

	// FIFO pointers and fill level
	always_ff @(posedge ref_clk) begin
		if (!reset_n || flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (rx_push & (~fifo_full | fifo_pop)) begin
				wr_ptr <= ptr_inc(wr_ptr);
			end
			if (fifo_pop) begin
				rd_ptr <= ptr_inc(rd_ptr);
			end
			if ((rx_push & ~fifo_full) & ~fifo_pop) begin
				count <= count + CW'(1);
			end else if (fifo_pop & ~rx_push) begin
				count <= count - CW'(1);
			end
		end
	end

	// Bit-time strobe from the 16x sampling ticks
	assign bit_tick = baud_tick & (bit_div == ubr_pkg::SAMPLE_LAST);

	always_ff @(posedge ref_clk) begin
		if (!reset_n || !rx_on) begin
			bit_div <= 4'h0;
		end else if (baud_tick) begin
			bit_div <= bit_div + 4'h1;
		end
	end

	// Age of the head character in bit times; restarts on every pop, saturates
	always_ff @(posedge ref_clk) begin
		if (!reset_n || flush || !fifo_ready || fifo_pop) begin
			age <= 5'h00;
		end else if (bit_tick && age != 5'h1f) begin
			age <= age + 5'h01;
		end
	end

	assign fifo_old = fifo_ready & (age > ubr_pkg::OLD_DATA_BITS);

	// Sticky interrupt events; a new event wins over a write-one clear
	always_comb begin
		irq_set                    = '0;
		irq_set[ubr_pkg::IRQ_FULL]  = status_valid & fifo_full;
		irq_set[ubr_pkg::IRQ_HALF]  = status_valid & fifo_half;
		irq_set[ubr_pkg::IRQ_READY] = status_valid & fifo_ready;
		irq_set[ubr_pkg::IRQ_OLD]   = status_valid & fifo_old;
		irq_set[ubr_pkg::IRQ_OVR]   = overwrite;
	end

	assign irq_clr = (wr_done && avs_address == ubr_pkg::REG_IRQ_STAT && avs_byteenable[0])
		? avs_writedata[ubr_pkg::IRQ_W-1:0] : '0;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			irq_status <= ubr_pkg::IRQ_RESET;
		end else begin
			irq_status <= (irq_status & ~irq_clr) | irq_set;
		end
	end

	// Control enables gate each source except overrun on top of the mask
	always_comb begin
		irq_gate                    = '0;
		irq_gate[ubr_pkg::IRQ_FULL]  = ctrl[ubr_pkg::CTRL_FULL_EN_BIT];
		irq_gate[ubr_pkg::IRQ_HALF]  = ctrl[ubr_pkg::CTRL_HALF_EN_BIT];
		irq_gate[ubr_pkg::IRQ_READY] = ctrl[ubr_pkg::CTRL_RDY_EN_BIT];
		irq_gate[ubr_pkg::IRQ_OLD]   = ctrl[ubr_pkg::CTRL_STALE_EN_BIT];
		irq_gate[ubr_pkg::IRQ_OVR]   = 1'b1;
	end

	assign irq = |(irq_status & irq_mask & irq_gate);
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the UART baud generator and receive status block
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DEPTH = 8;
	localparam int BITC  = 32; // Prescale 63, divide 0: tick every 2 clocks, 16 ticks a bit
	logic        ref_clk        = 1'h0;
	logic        reset_n        = 1'h0;
	logic [2:0]  avs_address    = 3'h0;
	logic        avs_read       = 1'h0;
	logic        avs_write      = 1'h0;
	logic [31:0] avs_writedata  = 32'h0;
	logic [3:0]  avs_byteenable = 4'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        rx_line;
	logic        uart_ext_clock_pin_in;
	logic        uart_ext_clock_pin_out;
	logic        uart_ext_clock_pin_oe;
	logic        irq;
	logic        pin_drv        = 1'h0;
	logic        pin_run        = 1'h0;
	logic [15:0] v;
	int          err_total      = 0;
	int          compares       = 0;
	int          cyc            = 0;
	ubr_uart_baud_rx #(.FIFO_DEPTH(DEPTH)) i_dut (.*);
	ubr_far_uart i_far (.ref_clk(ref_clk), .rx_line(rx_line));
	always #25 ref_clk = ~ref_clk;
	// Shared clock pin: port select taken as cleared, so the pin belongs to the block
	assign uart_ext_clock_pin_in = uart_ext_clock_pin_oe ? uart_ext_clock_pin_out : pin_drv;
	always @(posedge ref_clk) begin
		if (pin_run) begin
			pin_drv <= ~pin_drv;
		end
	end
	// Hang guard, well above the longest scenario sequence
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (err_total == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, exp, seen);
		end
	endtask
	// One transfer; held until waitrequest is sampled low, then released
	task automatic bus(input logic wr, input logic [2:0] a, input logic [15:0] d, input logic [1:0] be);
		avs_address    <= a;
		avs_write      <= wr;
		avs_read       <= ~wr;
		avs_writedata  <= {16'h0000, d};
		avs_byteenable <= {2'h0, be};
		// Only the hang guard ends a wait that never completes
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'h0);
		v = avs_readdata[15:0];
		avs_read  <= 1'h0;
		avs_write <= 1'h0;
		@(posedge ref_clk);
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		bus(1'h1, a, d, 2'h3);
	endtask
	task automatic rd(input logic [2:0] a, input string n, input logic [15:0] exp);
		bus(1'h0, a, 16'h0000, 2'h3);
		chk(n, v, exp);
	endtask
	// Clocks between two changes of the pin output
	task automatic gap(output int n);
		logic p;
		p = uart_ext_clock_pin_out;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (uart_ext_clock_pin_out === p && n < 600);
	endtask
	task automatic t_reset();
		rd(ubr_pkg::REG_BAUD, "baud reset", 16'h0000);
		rd(ubr_pkg::REG_CTRL, "ctrl reset", 16'h0000);
		rd(ubr_pkg::REG_IRQ_MASK, "mask reset", 16'h0000);
		wr(3'h5, 16'hffff);
		rd(3'h5, "unmapped", 16'h0000);
		chk("oe reset", uart_ext_clock_pin_oe, 1'h1 - 1'h1);
		chk("irq reset", irq, 32'h0);
	endtask
	// Direction, divide and prescale fields read back; direction bit drives the pin enable
	task automatic t_baud_bits();
		wr(ubr_pkg::REG_BAUD, 16'h273f);
		rd(ubr_pkg::REG_BAUD, "baud bits", 16'h273f);
		chk("oe out", uart_ext_clock_pin_oe, 32'h1);
		wr(ubr_pkg::REG_BAUD, 16'h0000);
		chk("oe in", uart_ext_clock_pin_oe, 32'h0);
	endtask
	// Pin toggles once per baud tick: period is (65 - prescale) * 2^divide
	task automatic t_rate();
		logic [15:0] cfg [4] = '{16'h203f, 16'h213e, 16'h233c, 16'h273f};
		int          per [4] = '{2, 6, 40, 256};
		int          n;
		wr(ubr_pkg::REG_CTRL, 16'h8000);
		for (int k = 0; k < 4; k++) begin
			wr(ubr_pkg::REG_BAUD, cfg[k]);
			gap(n); // First gap may straddle the change
			gap(n);
			chk("baud period", n, per[k]);
		end
		wr(ubr_pkg::REG_BAUD, 16'h003f);
	endtask
	// Enable first, then a narrow init read, then traffic
	task automatic t_rx_basic();
		wr(ubr_pkg::REG_CTRL, 16'hc000);
		bus(1'h0, ubr_pkg::REG_RX, 16'h0000, 2'h1);
		chk("init read", v, 16'h0000);
		i_far.send(8'ha5, BITC);
		rd(ubr_pkg::REG_RX, "one char", 16'h20a5);
		rd(ubr_pkg::REG_RX, "drained", 16'h0000);
	endtask
	// Stale data raises its flag; its interrupt passes only through the gate
	task automatic t_stale();
		wr(ubr_pkg::REG_CTRL, 16'hc080);
		wr(ubr_pkg::REG_IRQ_MASK, 16'h0008);
		i_far.send(8'h3c, BITC);
		repeat (1100) @(posedge ref_clk);
		chk("stale irq", irq, 32'h1);
		rd(ubr_pkg::REG_IRQ_STAT, "stale stat", 16'h000c);
		wr(ubr_pkg::REG_CTRL, 16'hc000);
		chk("gate off", irq, 32'h0);
		wr(ubr_pkg::REG_CTRL, 16'hc080);
		chk("gate on", irq, 32'h1);
		rd(ubr_pkg::REG_RX, "stale char", 16'h303c);
		rd(ubr_pkg::REG_RX, "stale gone", 16'h0000);
		wr(ubr_pkg::REG_IRQ_STAT, 16'h000c);
		chk("irq cleared", irq, 32'h0);
	endtask
	// One character past full overwrites the newest entry
	task automatic t_fill();
		int          c;
		logic [7:0]  d;
		wr(ubr_pkg::REG_CTRL, 16'hc000);
		wr(ubr_pkg::REG_IRQ_MASK, 16'h0000);
		wr(ubr_pkg::REG_IRQ_STAT, 16'h001f);
		for (int i = 0; i < DEPTH + 1; i++) i_far.send(8'(8'h10 + i), BITC);
		for (int i = 0; i < DEPTH; i++) begin
			c = DEPTH - i;
			d = (i == DEPTH - 1) ? 8'(8'h10 + DEPTH) : 8'(8'h10 + i);
			rd(ubr_pkg::REG_RX, "fifo read", {c == DEPTH, c >= DEPTH - 4, 1'h1, i == 0, i == DEPTH - 1, 3'h0, d});
		end
		rd(ubr_pkg::REG_IRQ_STAT, "fill stat", 16'h001f);
		wr(ubr_pkg::REG_IRQ_STAT, 16'h001f);
	endtask
	// Receiver off flushes held characters
	task automatic t_flush();
		i_far.send(8'h55, BITC);
		i_far.send(8'h66, BITC);
		wr(ubr_pkg::REG_CTRL, 16'h8000);
		rd(ubr_pkg::REG_RX, "flushed", 16'h0000);
		wr(ubr_pkg::REG_CTRL, 16'hc000);
		rd(ubr_pkg::REG_RX, "still empty", 16'h0000);
	endtask
	// Pin as source: pin rises every 2 clocks, so a bit lasts 64 clocks
	task automatic t_pin_src();
		pin_run <= 1'h1;
		wr(ubr_pkg::REG_BAUD, 16'h083f);
		chk("pin input", uart_ext_clock_pin_oe, 32'h0);
		i_far.send(8'h96, 2 * BITC);
		rd(ubr_pkg::REG_RX, "pin clocked", 16'h2096);
		pin_run <= 1'h0;
		wr(ubr_pkg::REG_BAUD, 16'h003f);
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		reset_n <= 1'h1;
		@(posedge ref_clk);
		t_reset();
		t_baud_bits();
		t_rate();
		t_rx_basic();
		t_stale();
		t_fill();
		t_flush();
		t_pin_src();
		complete_run();
	end
endmodule
`default_nettype wire

// *** verification/ubr_far_uart.sv ***
// Remote serial sender model that drives 8N1 frames onto the receive line
`default_nettype none
module ubr_far_uart (
	input  wire logic ref_clk,
	output logic      rx_line
);
	timeunit 1ns;
	timeprecision 1ns;
	// Line idles high between frames
	initial rx_line = 1'h1;
	// Start bit, eight data bits LSB first, stop bit; one level per bit_cyc clocks
	task automatic send(input logic [7:0] b, input int bit_cyc);
		logic [9:0] frame;
		frame = {1'h1, b, 1'h0};
		for (int i = 0; i < 10; i++) begin
			rx_line <= frame[i];
			repeat (bit_cyc) @(posedge ref_clk);
		end
	endtask
endmodule
`default_nettype wire

// *** verification/ubr_uart_baud_rx_chk.sv ***
// Port-level checker for the baud and receive status block
`default_nettype none
module ubr_uart_baud_rx_chk #(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic                       ref_clk,
	input wire logic                       reset_n,
	input wire logic [ubr_pkg::ADDR_W-1:0] avs_address,
	input wire logic                       avs_read,
	input wire logic                       avs_write,
	input wire logic [31:0]                avs_writedata,
	input wire logic [3:0]                 avs_byteenable,
	input wire logic [31:0]                avs_readdata,
	input wire logic                       avs_waitrequest,
	input wire logic                       rx_line,
	input wire logic                       uart_ext_clock_pin_in,
	input wire logic                       uart_ext_clock_pin_out,
	input wire logic                       uart_ext_clock_pin_oe,
	input wire logic                       irq
);
	logic rd_done;
	logic wr_done;
	logic rx_rd;
	// Completed transfers, seen at the edge where waitrequest is low
	assign rd_done = avs_read & ~avs_waitrequest;
	assign wr_done = avs_write & ~avs_waitrequest;
	assign rx_rd   = rd_done & (avs_address == ubr_pkg::REG_RX);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait state too long");
	a_wait_first: assert property ($rose(avs_read) |-> avs_waitrequest)
		else $error("read answered without wait state");
	a_upper_zero: assert property (rd_done |-> avs_readdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	a_unmapped_zero: assert property (rd_done && avs_address > 3'h4 |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_ovr_full_read: assert property (rx_rd && avs_byteenable[1:0] != 2'h3 |-> !avs_readdata[11])
		else $error("overrun shown on narrow read");
	a_empty_quiet: assert property (rx_rd && !avs_readdata[13]
		|-> avs_readdata[15:11] == 5'h00 && avs_readdata[7:0] == 8'h00)
		else $error("status or data set while empty");
	a_full_has_half: assert property (rx_rd && avs_readdata[15] |-> avs_readdata[14] && avs_readdata[13])
		else $error("full without half or ready");
	a_oe_follows_dir: assert property (wr_done && avs_address == ubr_pkg::REG_BAUD && avs_byteenable[1]
		|=> uart_ext_clock_pin_oe == $past(avs_writedata[13]))
		else $error("pin direction does not follow write");
	a_input_no_drive: assert property ((!uart_ext_clock_pin_oe) [*2] |-> !uart_ext_clock_pin_out)
		else $error("pin output active while input");
	a_mask_off_quiet: assert property (wr_done && avs_address == ubr_pkg::REG_IRQ_MASK && avs_byteenable[0]
		&& avs_writedata[4:0] == 5'h00 |=> !irq)
		else $error("irq with all sources masked");
	// Main scenarios reached
	c_rx_ready: cover property (rx_rd && avs_readdata[13]);
	c_irq_up: cover property ($rose(irq));
	c_pin_out: cover property (uart_ext_clock_pin_oe && $rose(uart_ext_clock_pin_out));
endmodule
bind ubr_uart_baud_rx ubr_uart_baud_rx_chk #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (.*);
`default_nettype wire
